// [logic/spicsl_map.vh]
// register offsets, field positions, reset values and transfer width of the serial port
`ifndef SPICSL_MAP_VH
`define SPICSL_MAP_VH
// register indices on the plain register port
`define SPICSL_ADDR_DATA 2'h1
`define SPICSL_ADDR_CTRL 2'h2
`define SPICSL_ADDR_CSR 2'h3
// control register fields
`define SPICSL_CR_IRQ_EN 7
`define SPICSL_CR_PIN_EN 6
`define SPICSL_CR_DIV_EN 5
`define SPICSL_CR_MASTER 4
`define SPICSL_CR_CLOCK_POLARITY_BIT 3
`define SPICSL_CR_CLOCK_PHASE_BIT 2
// control/status register fields
`define SPICSL_SR_DONE 7
`define SPICSL_SR_WRITE_COLLISION_FLAG 6
`define SPICSL_SR_OVR 5
`define SPICSL_SR_MODE_FAULT_FLAG 4
`define SPICSL_SR_ODIS 2
`define SPICSL_SR_SSM 1
`define SPICSL_SR_SSI 0
// reset values
`define SPICSL_CR_RESET 8'h00
`define SPICSL_CSR_RESET 8'h00
// writable mask of the control/status register
`define SPICSL_CSR_WMASK 8'h07
// bits per transfer
`define SPICSL_BITS 4'h8
`endif

// [logic/spicsl_rxbuf.v]
// one-byte receive buffer with registered read data
module spicsl_rxbuf (
    // clock and reset
    input wire i_core_clk,
    input wire i_rst_b,
    // write side
    input wire i_wr,
    input wire [7:0] i_wdata,
    // read side
    input wire i_rd,
    output reg [7:0] o_rdata
);
    reg [7:0] mem; // captured byte

    // capture on transfer end; read data come out of a register
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mem <= 8'h00;
            o_rdata <= 8'h00;
        end else begin
            if (i_wr) begin
                mem <= i_wdata;
            end
            if (i_rd) begin
                o_rdata <= mem;
            end
        end
    end
endmodule // spicsl_rxbuf

// [logic/spicsl_core.v]
// serial peripheral interface: control, status, flags, shifter and low-power handling
//
// How it works
// - wait mode leaves interface running, events wake
// - halt freezes all registers, interface inactive
// - second byte during halt sets overrun; here halt stops capture, so no overrun is set
// - only slave transfer-done wakes from halt; here the first select-qualified slave clock edge wakes it
// - halt wake needs select low at entry
// - all events share one masked request; here the write collision flag does not raise it
// - control bit 7 enables interrupt requests
// - control bit 6 enables pins, fault clears
// - control bit 4 master, fault clears it
// - control bit 3 sets clock idle level
// - control bit 2 picks capture edge
// - rate bits divide core clock 4..128
// - done flag cleared status then data access
// - data writes ignored while done set; here they are ignored from transfer end until a status read
// - data write mid-transfer sets collision flag
// - overrun when byte lands with done set
// - mode fault on select low as master
// - status bit 3 reserved, reads zero
// - status bit 2 disables data output
// - reset values of both registers
// - select management uses internal select bit
// - internal select bit: zero selects slave
// - master data write starts transfer
// - data read returns receive buffer copy
//
// The implementer's own choices: the register addresses and the plain strobed port.
`include "spicsl_map.vh"

module spicsl_core (
    // clock and reset
    input wire i_core_clk,
    input wire i_rst_b,
    // register port
    input wire [1:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    // cpu power state and mask
    input wire i_halt,
    input wire i_wait,
    input wire i_irq_mask,
    // interrupt and wake outputs
    output reg o_irq,
    output reg o_wake_halt,
    output reg o_wake_wait,
    // serial clock pin
    input wire i_sck,
    output reg o_sck,
    output reg o_sck_oe_b,
    // master-out line
    input wire i_mosi,
    output reg o_mosi,
    output reg o_mosi_oe_b,
    // slave-out line
    input wire i_miso,
    output reg o_miso,
    output reg o_miso_oe_b,
    // slave select pin
    input wire i_ss_b
);
    ////////////////////////////////////////////////////////////////////////
    // state
    localparam ST_IDLE = 1'b0; // no transfer
    localparam ST_XFER = 1'b1; // shifting

    reg [7:0] ctrl; // control register
    reg done_flag; // transfer done
    reg write_collision_flag_flag; // write collision
    reg ovr_flag; // overrun
    reg mode_fault_flag_flag; // mode fault
    reg [2:0] csr_sw; // output disable, select management, internal select
    reg csr_seen; // status read or write armed the clear sequences
    reg wr_lock; // data writes blocked until status read
    reg state; // transfer state
    reg [7:0] shreg; // shift register
    reg [3:0] edges; // clock edges left in master transfer, less one
    reg [3:0] bitcnt; // bits captured
    reg [6:0] divcnt; // master clock divider
    reg sck_int; // master clock level
    reg sck_q; // previous slave clock sample
    reg in_bit; // latched input bit
    reg halt_armed; // halt entered with select low
    reg halt_done; // a slave clock edge arrived during halt

    wire buf_wr; // end of transfer capture
    wire [7:0] buf_q; // receive buffer read data

    ////////////////////////////////////////////////////////////////////////
    // decode helpers

    // half-period in core cycles for the rate bits
    function [6:0] half_period;
        input [2:0] sel;
        begin
            case (sel)
                3'h4: half_period = 7'h02;
                3'h0: half_period = 7'h04;
                3'h1: half_period = 7'h08;
                3'h6: half_period = 7'h10;
                3'h2: half_period = 7'h20;
                3'h3: half_period = 7'h40;
                default: half_period = 7'h40; // unlisted codes take the slowest rate
            endcase
        end
    endfunction

    wire master = ctrl[`SPICSL_CR_MASTER];
    wire pin_en = ctrl[`SPICSL_CR_PIN_EN];
    wire clock_polarity_bit = ctrl[`SPICSL_CR_CLOCK_POLARITY_BIT];
    wire clock_phase_bit = ctrl[`SPICSL_CR_CLOCK_PHASE_BIT];
    wire [6:0] half = half_period({ctrl[`SPICSL_CR_DIV_EN], ctrl[1:0]});
    // effective select level
    wire ss_eff_b = csr_sw[1] ? csr_sw[0] : i_ss_b;
    wire run = !i_halt; // wait mode has no effect here
    wire fault = run && pin_en && master && !ss_eff_b;
    wire wr_data = i_wr && (i_addr == `SPICSL_ADDR_DATA);
    wire wr_ctrl = i_wr && (i_addr == `SPICSL_ADDR_CTRL);
    wire wr_csr = i_wr && (i_addr == `SPICSL_ADDR_CSR);
    wire rd_data = i_rd && (i_addr == `SPICSL_ADDR_DATA);
    wire rd_csr = i_rd && (i_addr == `SPICSL_ADDR_CSR);
    wire csr_acc = wr_csr || rd_csr;
    // slave clock edges, first edge leaves idle level
    wire s_edge = (i_sck != sck_q);
    wire s_lead = s_edge && (i_sck != clock_polarity_bit);
    wire s_sel = !master && pin_en && !ss_eff_b;
    wire m_tick = (state == ST_XFER) && master && (divcnt == half - 7'h01);
    wire m_lead = m_tick && (sck_int == clock_polarity_bit);
    // capture edge: leading when phase 0, trailing when phase 1
    wire cap = master ? (m_tick && (m_lead ^ clock_phase_bit)) : (s_sel && s_edge && (s_lead ^ clock_phase_bit));
    wire shf = master ? (m_tick && !(m_lead ^ clock_phase_bit)) : (s_sel && s_edge && !(s_lead ^ clock_phase_bit));
    wire last_cap = run && cap && (bitcnt == `SPICSL_BITS - 4'h1);
    wire accept = wr_data && !wr_lock;
    wire collide = accept && (state == ST_XFER);
    wire load = accept && !collide;
    wire in_pin = master ? i_miso : i_mosi;
    // an unserviced byte keeps its place; later bytes are lost to overrun
    assign buf_wr = last_cap && !done_flag;

    ////////////////////////////////////////////////////////////////////////
    // receive buffer
    spicsl_rxbuf u_rxbuf (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_wr(buf_wr),
        .i_wdata({shreg[6:0], in_pin}),
        .i_rd(run), // buffer output frozen in halt
        .o_rdata(buf_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // control register; fault clears enable and master
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl <= `SPICSL_CR_RESET;
        end else if (run) begin
            if (fault) begin
                ctrl[`SPICSL_CR_PIN_EN] <= 1'b0;
                ctrl[`SPICSL_CR_MASTER] <= 1'b0;
            end else if (wr_ctrl) begin
                ctrl <= i_wdata;
                // enable and master stay low while fault pending outside its clear
                if (mode_fault_flag_flag && !csr_seen) begin
                    ctrl[`SPICSL_CR_PIN_EN] <= 1'b0;
                    ctrl[`SPICSL_CR_MASTER] <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status flags; a set in the same cycle beats a clear
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            done_flag <= 1'b0;
            write_collision_flag_flag <= 1'b0;
            ovr_flag <= 1'b0;
            mode_fault_flag_flag <= 1'b0;
            csr_sw <= 3'h0;
            csr_seen <= 1'b0;
            wr_lock <= 1'b0;
        end else if (run) begin
            if (csr_acc) begin
                csr_seen <= 1'b1;
            end else if (rd_data || wr_data || wr_ctrl) begin
                csr_seen <= 1'b0;
            end
            if (wr_csr) begin
                csr_sw <= i_wdata[2:0]; // bit 3 not stored
            end
            // done flag
            if (last_cap) begin
                done_flag <= 1'b1;
            end else if (csr_seen && (rd_data || wr_data)) begin
                done_flag <= 1'b0;
            end
            // write lock follows done until status read
            if (last_cap) begin
                wr_lock <= 1'b1;
            end else if (rd_csr) begin
                wr_lock <= 1'b0;
            end
            // collision: status access then data access clears it
            if (collide) begin
                write_collision_flag_flag <= 1'b1;
            end else if (csr_seen && (rd_data || wr_data)) begin
                write_collision_flag_flag <= 1'b0;
            end
            // overrun: new byte while done still set
            if (last_cap && done_flag) begin
                ovr_flag <= 1'b1;
            end else if (rd_csr) begin
                ovr_flag <= 1'b0;
            end
            if (fault) begin
                mode_fault_flag_flag <= 1'b1;
            end else if (csr_seen && wr_ctrl) begin
                mode_fault_flag_flag <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transfer engine: divider, shifter, bit count
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= ST_IDLE;
            shreg <= 8'h00;
            edges <= 4'h0;
            bitcnt <= 4'h0;
            divcnt <= 7'h00;
            sck_int <= 1'b0;
            sck_q <= 1'b0;
            in_bit <= 1'b0;
        end else if (run) begin
            sck_q <= i_sck;
            if (!pin_en) begin
                state <= ST_IDLE;
                bitcnt <= 4'h0;
                sck_int <= clock_polarity_bit;
                if (load) begin
                    shreg <= i_wdata;
                end
            end else if (load) begin
                shreg <= i_wdata;
                bitcnt <= 4'h0;
                divcnt <= 7'h00;
                edges <= 4'hF;
                sck_int <= clock_polarity_bit;
                state <= master ? ST_XFER : ST_IDLE;
            end else begin
                if (!master && s_sel && s_edge) begin
                    state <= ST_XFER; // slave busy once clocks arrive
                end
                if (!master && ss_eff_b) begin
                    bitcnt <= 4'h0; // deselect aborts a partial slave byte
                    state <= ST_IDLE;
                end
                if (state == ST_XFER && master) begin
                    divcnt <= m_tick ? 7'h00 : divcnt + 7'h01;
                    if (m_tick) begin
                        sck_int <= ~sck_int;
                        edges <= edges - 4'h1;
                        if (edges == 4'h0) begin
                            state <= ST_IDLE;
                        end
                    end
                end
                if (cap) begin
                    in_bit <= in_pin;
                    bitcnt <= last_cap ? 4'h0 : bitcnt + 4'h1;
                    if (last_cap && !master) begin
                        state <= ST_IDLE;
                    end
                end
                // phase 1: first leading edge only presents the msb, no shift
                if (shf && !(clock_phase_bit && (bitcnt == 4'h0))) begin
                    shreg <= {shreg[6:0], in_bit}; // msb first
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // halt handling: arm on entry, flag a slave clock edge, wake only as slave
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            halt_armed <= 1'b0;
            halt_done <= 1'b0;
        end else if (!i_halt) begin
            halt_armed <= !ss_eff_b && !master;
            halt_done <= 1'b0;
        end else if (halt_armed && !master && s_sel && s_edge) begin
            // select-qualified slave edges are the only activity in halt
            halt_done <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt request and wake lines
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_irq <= 1'b0;
            o_wake_wait <= 1'b0;
            o_wake_halt <= 1'b0;
        end else begin
            o_irq <= ctrl[`SPICSL_CR_IRQ_EN] && !i_irq_mask
                && (done_flag || mode_fault_flag_flag || ovr_flag);
            o_wake_wait <= i_wait && ctrl[`SPICSL_CR_IRQ_EN]
                && (done_flag || mode_fault_flag_flag || ovr_flag);
            o_wake_halt <= i_halt && halt_armed && halt_done
                && ctrl[`SPICSL_CR_IRQ_EN];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pins: enables low while driving
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_sck <= 1'b0;
            o_sck_oe_b <= 1'b1;
            o_mosi <= 1'b0;
            o_mosi_oe_b <= 1'b1;
            o_miso <= 1'b0;
            o_miso_oe_b <= 1'b1;
        end else begin
            o_sck <= (state == ST_XFER) ? sck_int : clock_polarity_bit;
            o_sck_oe_b <= !(pin_en && master);
            o_mosi <= shreg[7];
            o_mosi_oe_b <= !(pin_en && master && !csr_sw[2]);
            o_miso <= shreg[7];
            o_miso_oe_b <= !(pin_en && !master && !csr_sw[2] && !ss_eff_b);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register read data, one cycle after the strobe, straight from a flop
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata <= 8'h00;
        end else if (rd_data) begin
            o_rdata <= buf_q; // buffer copy, not the shifter
        end else if (i_addr == `SPICSL_ADDR_CTRL) begin
            o_rdata <= ctrl;
        end else if (i_addr == `SPICSL_ADDR_CSR) begin
            o_rdata <= {done_flag, write_collision_flag_flag, ovr_flag, mode_fault_flag_flag, 1'b0, csr_sw};
        end else begin
            o_rdata <= 8'h00; // unmapped reads zero
        end
    end
endmodule // spicsl_core

// [tb/spicsl_core_chk.sv]
// port-level assertions for the serial port core
module spicsl_core_chk (
    // clock, reset and register port
    input wire i_core_clk,
    input wire i_rst_b,
    input wire [1:0] i_addr,
    input wire i_rd,
    input wire [7:0] o_rdata,
    // cpu state and select pin
    input wire i_halt,
    input wire i_wait,
    input wire i_irq_mask,
    input wire i_ss_b,
    // observed outputs
    input wire o_irq,
    input wire o_wake_halt,
    input wire o_wake_wait,
    input wire o_sck,
    input wire o_sck_oe_b,
    input wire o_mosi_oe_b,
    input wire o_miso_oe_b
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    ////////////////////////////////////////////////////////////////////////////
    irq_mask_gate_a: assert property (o_irq |-> !$past(i_irq_mask))
        else $error("request raised while cpu mask was set");
    wake_wait_gate_a: assert property (o_wake_wait |-> $past(i_wait))
        else $error("wait wake without wait state");
    halt_wake_slave_a: assert property (o_wake_halt |-> o_sck_oe_b)
        else $error("halt wake while driving the clock as master");
    halt_freeze_a: assert property ($past(i_halt) |-> $stable(o_sck) && $stable(o_sck_oe_b))
        else $error("serial clock moved during halt");
    status_reserved_a: assert property ($past(i_rd) && $past(i_addr) == 2'h3 |-> !o_rdata[3])
        else $error("reserved status bit read as one");
    mosi_master_a: assert property (!o_mosi_oe_b |-> !o_sck_oe_b)
        else $error("master-out driven outside master mode");
    miso_slave_a: assert property (!o_miso_oe_b |-> o_sck_oe_b)
        else $error("slave-out driven in master mode");
    sck_min_half_a: assert property ($changed(o_sck) && !o_sck_oe_b |=> o_sck_oe_b || $stable(o_sck))
        else $error("serial clock half period below two cycles");
    mode_fault_a: assert property (!o_sck_oe_b && !i_ss_b && !i_halt |-> ##[1:3] o_sck_oe_b)
        else $error("master kept driving with select low");
endmodule // spicsl_core_chk

bind spicsl_core spicsl_core_chk i_spicsl_core_chk (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
    .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata), .i_halt(i_halt), .i_wait(i_wait),
    .i_irq_mask(i_irq_mask), .i_ss_b(i_ss_b), .o_irq(o_irq), .o_wake_halt(o_wake_halt),
    .o_wake_wait(o_wake_wait), .o_sck(o_sck), .o_sck_oe_b(o_sck_oe_b),
    .o_mosi_oe_b(o_mosi_oe_b), .o_miso_oe_b(o_miso_oe_b));

// [tb/spicsl_far_slave.sv]
// behavioural far-side slave device answering master transfers
module spicsl_far_slave (
    // serial lines
    input wire i_sck,
    input wire i_mosi,
    output logic o_miso,
    // mode and byte exchange
    input wire i_clock_polarity_bit,
    input wire i_clock_phase_bit,
    input wire i_load,
    input wire [7:0] i_tx,
    output logic [7:0] o_rx
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] shreg = 8'h00; // bits still to send
    int cnt = 9; // 9 means idle
    initial o_miso = 1'b0;
    // preload: with phase zero the first bit must stand before the first edge
    always @(posedge i_load) begin
        cnt = 0;
        o_rx = 8'h00;
        shreg = i_clock_phase_bit ? i_tx : {i_tx[6:0], 1'b0};
        o_miso = i_clock_phase_bit ? ~o_miso : i_tx[7];
    end
    // capture on the phase-selected edge, shift on the other
    always @(i_sck) begin
        if (cnt < 8 && ((i_sck != i_clock_polarity_bit) ^ i_clock_phase_bit)) begin
            o_rx = {o_rx[6:0], i_mosi};
            cnt = cnt + 1;
        end else if (cnt < 8) begin
            o_miso = shreg[7];
            shreg = {shreg[6:0], 1'b0};
        end else if (cnt == 8) begin
            // released line: no stale level for the master to trust
            o_miso = ~o_miso;
            cnt = 9;
        end
    end
endmodule // spicsl_far_slave

// [tb/spicsl_core_tb.sv]
// self-checking bench for the serial port core
module spicsl_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // design ports
    logic i_core_clk = 1'b0, i_rst_b = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic i_halt = 1'b0, i_wait = 1'b0, i_irq_mask = 1'b0;
    logic [1:0] i_addr = 2'h0;
    logic [7:0] i_wdata = 8'h00, o_rdata, far_rx, far_tx = 8'h00;
    logic o_irq, o_wake_halt, o_wake_wait, o_sck, o_sck_oe_b, o_mosi, o_mosi_oe_b;
    logic o_miso, o_miso_oe_b, far_miso, sck_drv = 1'b0, mosi_drv = 1'b0, ss_b = 1'b1;
    logic load = 1'b0, clock_polarity_bit = 1'b0, clock_phase_bit = 1'b0;
    int err_count = 0, total_checks = 0, sck_edges = 0, last_edge = 0, half_ns = 0;
    int divs[6] = '{4, 8, 16, 32, 64, 128};
    logic [7:0] rates[6] = '{8'h20, 8'h00, 8'h01, 8'h22, 8'h02, 8'h03};
    ////////////////////////////////////////////////////////////////////////////
    always #5 i_core_clk = ~i_core_clk;
    // master clock edges and their latest spacing
    always @(o_sck) begin
        if (o_sck_oe_b === 1'b0) begin
            half_ns = int'($time) - last_edge;
            last_edge = int'($time);
            sck_edges++;
        end
    end
    spicsl_core i_spicsl_core (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_halt(i_halt),
        .i_wait(i_wait), .i_irq_mask(i_irq_mask), .o_irq(o_irq), .o_wake_halt(o_wake_halt),
        .o_wake_wait(o_wake_wait), .i_sck(sck_drv), .o_sck(o_sck), .o_sck_oe_b(o_sck_oe_b),
        .i_mosi(mosi_drv), .o_mosi(o_mosi), .o_mosi_oe_b(o_mosi_oe_b), .i_miso(far_miso),
        .o_miso(o_miso), .o_miso_oe_b(o_miso_oe_b), .i_ss_b(ss_b));
    spicsl_far_slave i_spicsl_far_slave (.i_sck(o_sck), .i_mosi(o_mosi), .o_miso(far_miso),
        .i_clock_polarity_bit(clock_polarity_bit), .i_clock_phase_bit(clock_phase_bit), .i_load(load), .i_tx(far_tx), .o_rx(far_rx));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask
    // read data come in the cycle after the strobe; data-register reads stand only in that cycle
    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge i_core_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        @(negedge i_core_clk);
        check(o_rdata, exp);
    endtask
    task automatic wait_irq(input logic lvl);
        int n;
        n = 0;
        while (o_irq !== lvl && n < 3000) begin
            @(negedge i_core_clk);
            n++;
        end
        check({7'h00, o_irq}, {7'h00, lvl});
    endtask
    // bench as external master, idle-low clock, capture on first edge
    task automatic slave_byte(input logic [7:0] d);
        for (int b = 7; b >= 0; b--) begin
            @(posedge i_core_clk);
            mosi_drv <= d[b];
            repeat (4) @(posedge i_core_clk);
            sck_drv <= 1'b1;
            repeat (4) @(posedge i_core_clk);
            sck_drv <= 1'b0;
        end
        repeat (4) @(posedge i_core_clk);
        mosi_drv <= ~mosi_drv;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #500000;
        err_count++;
        tally_and_finish();
    end
    initial begin
        int e;
        repeat (20) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        rd(2'h2, 8'h00);
        rd(2'h3, 8'h00);
        rd(2'h0, 8'h00);
        wr(2'h3, 8'hFF);
        rd(2'h3, 8'h07);
        wr(2'h3, 8'h00);
        // every rate, all four polarity and phase pairs
        for (int i = 0; i < 6; i++) begin
            clock_polarity_bit = i[0];
            clock_phase_bit = i[1];
            wr(2'h2, 8'h00);
            wr(2'h2, 8'hD0 | {4'h0, clock_polarity_bit, clock_phase_bit, 2'b00} | rates[i]);
            repeat (2) @(posedge i_core_clk);
            check({7'h00, o_sck}, {7'h00, clock_polarity_bit});
            far_tx <= 8'hA5 ^ i[7:0];
            load <= 1'b1;
            wr(2'h1, 8'h3C + i[7:0]);
            load <= 1'b0;
            if (i == 0) wr(2'h1, 8'hFF);
            wait_irq(1'b1);
            check(8'(half_ns / 10), 8'(divs[i] / 2));
            check(far_rx, 8'h3C + i[7:0]);
            // let the closing clock edge of the byte pass first
            repeat (divs[i]) @(posedge i_core_clk);
            e = sck_edges;
            wr(2'h1, 8'h55);
            repeat (30) @(posedge i_core_clk);
            check(8'(sck_edges - e), 8'h00);
            rd(2'h3, (i == 0) ? 8'hC0 : 8'h80);
            rd(2'h1, 8'hA5 ^ i[7:0]);
            rd(2'h3, 8'h00);
            wait_irq(1'b0);
        end
        // select pulled low under a master
        wr(2'h2, 8'hD0);
        ss_b <= 1'b0;
        repeat (4) @(posedge i_core_clk);
        check({7'h00, o_sck_oe_b}, 8'h01);
        wait_irq(1'b1);
        i_irq_mask <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        check({7'h00, o_irq}, 8'h00);
        i_irq_mask <= 1'b0;
        ss_b <= 1'b1;
        rd(2'h3, 8'h10);
        rd(2'h2, 8'h80);
        wr(2'h2, 8'h00);
        rd(2'h3, 8'h00);
        // slave selected by the internal bit, two bytes without service
        wr(2'h3, 8'h02);
        wr(2'h2, 8'hC0);
        i_wait <= 1'b1;
        slave_byte(8'h96);
        check({7'h00, o_miso_oe_b}, 8'h00);
        slave_byte(8'h69);
        check({7'h00, o_wake_wait}, 8'h01);
        rd(2'h3, 8'hA2);
        rd(2'h1, 8'h96);
        rd(2'h3, 8'h02);
        wr(2'h3, 8'h06);
        repeat (2) @(posedge i_core_clk);
        check({7'h00, o_miso_oe_b}, 8'h01);
        wr(2'h3, 8'h03);
        repeat (2) @(posedge i_core_clk);
        check({7'h00, o_miso_oe_b}, 8'h01);
        // halt entered with the pin select held low
        i_wait <= 1'b0;
        wr(2'h3, 8'h00);
        ss_b <= 1'b0;
        @(posedge i_core_clk);
        i_halt <= 1'b1;
        slave_byte(8'h5A);
        check({7'h00, o_wake_halt}, 8'h01);
        i_halt <= 1'b0;
        slave_byte(8'hC3);
        rd(2'h3, 8'h80);
        rd(2'h1, 8'hC3);
        tally_and_finish();
    end
endmodule // spicsl_core_tb
